/* hw/dmi_data_memory.sv */
// special area, indirect ports, memory pointers and accumulator of the data memory
`timescale 1ns/100ps
//Behaviour
// [RULE1] Unused special-area addresses, up to 3FH, read back as 00H.
// [RULE2] Special registers start at address 00H, all in bank 0.
// [RULE3] Indirect port zero/one accesses go to the address in pointer zero/one.
// [RULE4] Indirect ports hold nothing; reached through a pointer they read 00H, ignore writes.
// [RULE5] Both pointers are real registers, readable and writable like any other.
// [RULE6] Every ALU result is written into the accumulator, never straight to memory.
// [RULE7] No register-to-register move; data passes through the accumulator.
// [RULE8] Pointers are eight bits and form the whole address unmodified.
module dmi_data_memory #(
  parameter int GPR_DEPTH = dmi_pkg::GPR_DEPTH
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic rdEn,
  input wire logic rdToAcc,
  input wire logic memWr,
  input wire logic [dmi_pkg::ADDR_W-1:0] addr,
  input wire logic aluWr,
  input wire logic [dmi_pkg::DATA_W-1:0] aluResult,
  input wire logic [dmi_pkg::DATA_W-1:0] conversionResultLow,
  input wire logic [dmi_pkg::DATA_W-1:0] conversionResultHigh,
  output logic [dmi_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  output logic [dmi_pkg::DATA_W-1:0] accumulator,
  output logic [dmi_pkg::DATA_W-1:0] pointerZero,
  output logic [dmi_pkg::DATA_W-1:0] pointerOne,
  output logic [dmi_pkg::DATA_W-1:0] interruptControlSecond,
  output logic [dmi_pkg::DATA_W-1:0] pulseWidthDuty,
  output logic [dmi_pkg::DATA_W-1:0] converterControl,
  output logic [dmi_pkg::DATA_W-1:0] converterClockSelect
);
  import dmi_pkg::*;

  localparam logic [7:0] GPR_LAST = GPR_BASE + 8'(GPR_DEPTH - 1);

  logic [7:0] effAddr;
  logic viaPort;
  logic selfRef;
  logic inRam;
  logic wrOk;
  logic [7:0] sfrValue;
  logic [GPR_IDX_W-1:0] ramIdx;
  logic [7:0] ramQ;
  logic [7:0] readValue;
  logic stage_reg;
  logic stageToAcc_reg;
  logic stageRam_reg;
  logic [7:0] stageSfr_reg;

  // address resolution through the pointers
  always_comb begin
    effAddr = addr;
    if (addr == IND_ZERO_ADDR) begin
      effAddr = pointerZero; // [RULE3] [RULE8]
    end else if (addr == IND_ONE_ADDR) begin
      effAddr = pointerOne; // [RULE3] [RULE8]
    end
  end

  assign viaPort = (addr == IND_ZERO_ADDR) || (addr == IND_ONE_ADDR);
  assign selfRef = viaPort && ((effAddr == IND_ZERO_ADDR) || (effAddr == IND_ONE_ADDR)); // [RULE4]
  assign inRam = (effAddr >= GPR_BASE) && (effAddr <= GPR_LAST);
  assign wrOk = memWr && !selfRef; // [RULE4]
  assign ramIdx = GPR_IDX_W'(effAddr - GPR_BASE);

  // special area read decode; holes and unlisted addresses give zero
  always_comb begin
    case (effAddr)
      PTR_ZERO_ADDR: sfrValue = pointerZero; // [RULE5]
      PTR_ONE_ADDR: sfrValue = pointerOne; // [RULE5]
      ACC_ADDR: sfrValue = accumulator; // [RULE2]
      INT_CTRL2_ADDR: sfrValue = interruptControlSecond;
      PWM_DUTY_ADDR: sfrValue = pulseWidthDuty;
      CONV_LOW_ADDR: sfrValue = conversionResultLow;
      CONV_HIGH_ADDR: sfrValue = conversionResultHigh;
      CONV_CTRL_ADDR: sfrValue = converterControl;
      CONV_CLK_ADDR: sfrValue = converterClockSelect;
      default: sfrValue = ZERO_BYTE; // [RULE1] [RULE4]
    endcase
  end

  dmi_gpr_ram #(
    .DEPTH(GPR_DEPTH),
    .IDX_W(GPR_IDX_W),
    .WIDTH(DATA_W)
  ) u_ram (
    .clock(clock),
    .arst_n(arst_n),
    .wrEn(wrOk && inRam),
    .wrIdx(ramIdx),
    .wrData(accumulator), // [RULE7]
    .rdIdx(ramIdx),
    .rdData_reg(ramQ)
  );

  // first read stage: decode captured while the memory array is read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= 1'b0;
      stageToAcc_reg <= 1'b0;
      stageRam_reg <= 1'b0;
      stageSfr_reg <= ZERO_BYTE;
    end else begin
      stage_reg <= rdEn;
      stageToAcc_reg <= rdEn && rdToAcc;
      stageRam_reg <= inRam && !selfRef;
      stageSfr_reg <= selfRef ? ZERO_BYTE : sfrValue; // [RULE4]
    end
  end

  assign readValue = stageRam_reg ? ramQ : stageSfr_reg;

  // second read stage: answer to the core
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= ZERO_BYTE;
      rdValid <= 1'b0;
    end else begin
      rdValid <= stage_reg;
      rdData <= stage_reg ? readValue : ZERO_BYTE;
    end
  end

  // accumulator: alu results win over a load from memory
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      accumulator <= ACC_RESET;
    end else if (aluWr) begin
      accumulator <= aluResult; // [RULE6]
    end else if (stageToAcc_reg) begin
      accumulator <= readValue; // [RULE7]
    end
  end

  // pointers take the accumulator on a store
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pointerZero <= PTR_RESET;
      pointerOne <= PTR_RESET;
    end else if (wrOk) begin
      if (effAddr == PTR_ZERO_ADDR) begin
        pointerZero <= accumulator; // [RULE5] [RULE7]
      end
      if (effAddr == PTR_ONE_ADDR) begin
        pointerOne <= accumulator; // [RULE5] [RULE7]
      end
    end
  end

  // writable special registers of this area
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      interruptControlSecond <= SFR_RESET;
      pulseWidthDuty <= SFR_RESET;
      converterControl <= SFR_RESET;
      converterClockSelect <= SFR_RESET;
    end else if (wrOk) begin
      case (effAddr)
        INT_CTRL2_ADDR: interruptControlSecond <= accumulator; // [RULE7]
        PWM_DUTY_ADDR: pulseWidthDuty <= accumulator; // [RULE7]
        CONV_CTRL_ADDR: converterControl <= accumulator; // [RULE7]
        CONV_CLK_ADDR: converterClockSelect <= accumulator; // [RULE7]
        default: ;
      endcase
    end
  end

  unused_zero_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE1]
    rdEn && (addr > CONV_CLK_ADDR) && (addr <= SFR_LAST_ADDR) |-> ##2 rdValid && rdData == 8'h00)
    else $error("unused special address did not read zero");

  acc_at_five_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE2]
    rdEn && addr == ACC_ADDR |-> ##2 rdData == $past(accumulator, 2))
    else $error("accumulator not read at its address");

  port_redirect_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE3]
    memWr && addr == IND_ZERO_ADDR && pointerZero == PWM_DUTY_ADDR
    |=> pulseWidthDuty == $past(accumulator))
    else $error("indirect port zero did not follow pointer zero");

  self_read_zero_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE4]
    rdEn && addr == IND_ZERO_ADDR && (pointerZero == IND_ZERO_ADDR || pointerZero == IND_ONE_ADDR)
    |-> ##2 rdData == 8'h00)
    else $error("indirect port read through pointer was not zero");

  self_write_none_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE4]
    memWr && addr == IND_ONE_ADDR && pointerOne == IND_ZERO_ADDR
    |=> $stable(pointerZero) && $stable(pointerOne) && $stable(pulseWidthDuty))
    else $error("indirect port write through pointer changed state");

  ptr_readback_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE5]
    rdEn && addr == PTR_ONE_ADDR |-> ##2 rdData == $past(pointerOne, 2))
    else $error("pointer one read back wrong");

  alu_to_acc_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE6]
    aluWr |=> accumulator == $past(aluResult))
    else $error("alu result not in accumulator");

  load_acc_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE7]
    rdEn && rdToAcc ##1 !aluWr |=> accumulator == rdData && rdValid)
    else $error("load did not reach accumulator");

  ptr_full_addr_a: assert property (@(posedge clock) disable iff (!arst_n) // [RULE8]
    memWr && addr == IND_ONE_ADDR && pointerOne == PTR_ZERO_ADDR
    |=> pointerZero == $past(accumulator))
    else $error("pointer one not used as full address");
endmodule

/* hw/dmi_gpr_ram.sv */
// general purpose data memory with registered read data
`timescale 1ns/100ps
module dmi_gpr_ram #(
  parameter int DEPTH = dmi_pkg::GPR_DEPTH,
  parameter int IDX_W = dmi_pkg::GPR_IDX_W,
  parameter int WIDTH = dmi_pkg::DATA_W
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [IDX_W-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [IDX_W-1:0] rdIdx,
  output logic [WIDTH-1:0] rdData_reg
);
  import dmi_pkg::*;

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= mem[rdIdx];
    end
  end
endmodule

/* hw/dmi_pkg.sv */
// address map, field widths and reset values of the data memory special area
package dmi_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int RD_LATENCY = 2;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] SFR_BASE = 8'h00;
  localparam logic [7:0] IND_ZERO_ADDR = 8'h00;
  localparam logic [7:0] PTR_ZERO_ADDR = 8'h01;
  localparam logic [7:0] IND_ONE_ADDR = 8'h02;
  localparam logic [7:0] PTR_ONE_ADDR = 8'h03;
  localparam logic [7:0] ACC_ADDR = 8'h05;
  localparam logic [7:0] INT_CTRL2_ADDR = 8'h1E;
  localparam logic [7:0] PWM_DUTY_ADDR = 8'h1F;
  localparam logic [7:0] CONV_LOW_ADDR = 8'h20;
  localparam logic [7:0] CONV_HIGH_ADDR = 8'h21;
  localparam logic [7:0] CONV_CTRL_ADDR = 8'h22;
  localparam logic [7:0] CONV_CLK_ADDR = 8'h23;
  localparam logic [7:0] SFR_LAST_ADDR = 8'h3F;
  localparam logic [7:0] GPR_BASE = 8'h40;
  localparam int GPR_DEPTH = 96;
  localparam int GPR_IDX_W = 7;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] SFR_RESET = 8'h00;
endpackage

/* verif/dmi_core_model.sv */
// instruction core model: issues reads, accumulator stores and alu writes
`timescale 1ns/100ps
module dmi_core_model (
  input wire logic clock,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  output logic rdEn,
  output logic rdToAcc,
  output logic memWr,
  output logic [7:0] addr,
  output logic aluWr,
  output logic [7:0] aluResult
);
  initial begin
    rdEn = 1'b0;
    rdToAcc = 1'b0;
    memWr = 1'b0;
    addr = 8'h00;
    aluWr = 1'b0;
    aluResult = 8'h00;
  end
  // idle lines show the inverse of the last value
  task automatic alu(input logic [7:0] d);
    @(negedge clock);
    aluWr = 1'b1;
    aluResult = d;
    @(negedge clock);
    aluWr = 1'b0;
    aluResult = ~d;
  endtask
  // a store carries no data: the accumulator is the only source
  task automatic store(input logic [7:0] a);
    @(negedge clock);
    memWr = 1'b1;
    addr = a;
    @(negedge clock);
    memWr = 1'b0;
    addr = ~a;
  endtask
  task automatic load(input logic [7:0] a, input logic toAcc, output logic [7:0] v,
                      output logic ok);
    @(negedge clock);
    rdEn = 1'b1;
    rdToAcc = toAcc;
    addr = a;
    @(negedge clock);
    rdEn = 1'b0;
    rdToAcc = 1'b0;
    addr = ~a;
    @(negedge clock);
    ok = rdValid;
    v = rdData;
  endtask
endmodule

/* verif/tb.sv */
// testbench: pointers, indirect ports, unused space and accumulator moves
`timescale 1ns/100ps
module tb;
  import dmi_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic rdEn, rdToAcc, memWr, aluWr, rdValid;
  logic [7:0] addr, aluResult, rdData, acc, p0, p1, ic2, pwd, cc, ccs;
  int fail_count = 0;
  int n_compared = 0;
  always #4 clock = ~clock;
  dmi_data_memory i_dut (.clock(clock), .arst_n(arst_n), .rdEn(rdEn), .rdToAcc(rdToAcc),
    .memWr(memWr), .addr(addr), .aluWr(aluWr), .aluResult(aluResult),
    .conversionResultLow(8'h5A), .conversionResultHigh(8'hC3), .rdData(rdData),
    .rdValid(rdValid), .accumulator(acc), .pointerZero(p0), .pointerOne(p1),
    .interruptControlSecond(ic2), .pulseWidthDuty(pwd), .converterControl(cc),
    .converterClockSelect(ccs));
  dmi_core_model i_core (.clock(clock), .rdValid(rdValid), .rdData(rdData), .rdEn(rdEn),
    .rdToAcc(rdToAcc), .memWr(memWr), .addr(addr), .aluWr(aluWr), .aluResult(aluResult));
  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    i_core.load(a, 1'b0, v, ok);
    check("rdValid", {7'h00, ok}, 8'h01);
    check($sformatf("read %h", a), v, exp);
  endtask
  task automatic put(input logic [7:0] d, input logic [7:0] a);
    i_core.alu(d);
    i_core.store(a);
  endtask
  task automatic t_pointers;
    check("reset pointer", p0 | p1 | acc, 8'h00);
    put(8'h40, PTR_ZERO_ADDR);
    check("pointerZero", p0, 8'h40);
    rd(PTR_ZERO_ADDR, 8'h40);
    put(8'h9F, PTR_ONE_ADDR);
    rd(PTR_ONE_ADDR, 8'h9F);
  endtask
  task automatic t_indirect;
    put(8'hA5, IND_ZERO_ADDR);
    rd(8'h40, 8'hA5);
    put(8'h3C, IND_ONE_ADDR);
    rd(8'h9F, 8'h3C);
    rd(IND_ONE_ADDR, 8'h3C);
    rd(IND_ZERO_ADDR, 8'hA5);
  endtask
  task automatic t_self;
    put(8'h00, PTR_ZERO_ADDR);
    put(8'h77, IND_ZERO_ADDR);
    rd(IND_ZERO_ADDR, 8'h00);
    rd(8'h40, 8'hA5);
    put(8'h02, PTR_ONE_ADDR);
    rd(IND_ONE_ADDR, 8'h00);
  endtask
  task automatic t_unused;
    logic [7:0] list [5] = '{8'h04, 8'h06, 8'h1D, 8'h24, 8'h3F};
    foreach (list[i]) begin
      put(8'hFF, list[i]);
      rd(list[i], 8'h00);
    end
  endtask
  task automatic t_sfr;
    put(8'h81, INT_CTRL2_ADDR);
    check("interruptControlSecond", ic2, 8'h81);
    i_core.store(PWM_DUTY_ADDR);
    check("pulseWidthDuty", pwd, 8'h81);
    i_core.store(CONV_LOW_ADDR);
    rd(CONV_LOW_ADDR, 8'h5A);
    rd(CONV_HIGH_ADDR, 8'hC3);
  endtask
  task automatic t_move;
    logic [7:0] v;
    logic ok;
    i_core.alu(8'h00);
    i_core.load(PWM_DUTY_ADDR, 1'b1, v, ok);
    check("accumulator", acc, 8'h81);
    i_core.store(8'h41);
    rd(8'h41, 8'h81);
    i_core.alu(8'h6E);
    check("accumulator", acc, 8'h6E);
  endtask
  task automatic t_reach;
    put(8'h1F, PTR_ZERO_ADDR);
    put(8'h4B, IND_ZERO_ADDR);
    check("pulseWidthDuty", pwd, 8'h4B);
    rd(PWM_DUTY_ADDR, 8'h4B);
    put(8'h22, CONV_CTRL_ADDR);
    check("converterControl", cc, 8'h22);
    put(8'hD7, CONV_CLK_ADDR);
    check("converterClockSelect", ccs, 8'hD7);
    rd(CONV_CTRL_ADDR, 8'h22);
    rd(CONV_CLK_ADDR, 8'hD7);
    rd(INT_CTRL2_ADDR, 8'h81);
    rd(ACC_ADDR, 8'hD7);
    put(8'h01, PTR_ONE_ADDR);
    put(8'h5C, IND_ONE_ADDR);
    check("pointerZero", p0, 8'h5C);
    put(8'h00, PTR_ONE_ADDR);
    put(8'hE1, IND_ONE_ADDR);
    check("pointerZero", p0, 8'h5C);
    check("pointerOne", p1, 8'h00);
    check("pulseWidthDuty", pwd, 8'h4B);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    t_pointers();
    t_indirect();
    t_self();
    t_unused();
    t_sfr();
    t_move();
    t_reach();
    tally_and_finish();
  end
  initial begin
    #50000;
    fail_count++;
    tally_and_finish();
  end
endmodule
